//--- gst_edge_sync.sv
// Two-stage synchroniser with rising-edge output for one asynchronous level.
// Assumes the input comes from another clock or a pin.
`timescale 1ns/100ps
`default_nettype none
module gst_edge_sync (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
endmodule
`default_nettype wire

//--- gst_pkg.sv
// Package for the gated sixteen-bit timer: register map, field positions, resets.
// Assumes a 16-bit register port with byte-free word accesses.
package gst_pkg;

  // ----------------------------------------
  // Register indices on the plain port
  // ----------------------------------------
  localparam logic [1:0] GST_ADDR_CTRL  = 2'h0;
  localparam logic [1:0] GST_ADDR_GATE  = 2'h1;
  localparam logic [1:0] GST_ADDR_COUNT = 2'h2;
  localparam logic [1:0] GST_ADDR_FLAG  = 2'h3;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int GST_CTRL_RUN    = 0;
  localparam int GST_CTRL_SYNCB  = 2;
  localparam int GST_CTRL_OSCSEL = 3;
  localparam int GST_CTRL_PS_LO  = 4;
  localparam int GST_CTRL_CS_LO  = 6;
  localparam int GST_GATE_SS_LO  = 0;
  localparam int GST_GATE_VAL    = 2;
  localparam int GST_GATE_GO     = 3;
  localparam int GST_GATE_SPM    = 4;
  localparam int GST_GATE_TM     = 5;
  localparam int GST_GATE_POL    = 6;
  localparam int GST_GATE_EN     = 7;

  // Writable bit masks; bit 1 of control and the upper bytes are absent
  localparam logic [7:0] GST_CTRL_MASK = 8'hFD;

  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [7:0]  GST_CTRL_RST  = 8'h00;
  localparam logic [7:0]  GST_GATE_RST  = 8'h00;
  localparam logic [15:0] GST_COUNT_RST = 16'h0000;

  localparam logic [1:0] GST_CS_INSTR = 2'h0;
  localparam logic [1:0] GST_CS_SYS   = 2'h1;
  localparam logic [1:0] GST_CS_EXT   = 2'h2;
  localparam logic [1:0] GST_CS_LOW_POWER_RC_OSC  = 2'h3;

  localparam logic [1:0] GST_GS_PIN  = 2'h0;
  localparam logic [1:0] GST_GS_MAT  = 2'h1;
  localparam logic [1:0] GST_GS_CMP1 = 2'h2;
  localparam logic [1:0] GST_GS_CMP2 = 2'h3;

  typedef enum logic [1:0] {
    GST_SP_IDLE = 2'b00,
    GST_SP_WAIT = 2'b01,
    GST_SP_OPEN = 2'b11
  } gst_sp_e;

endpackage

//--- gst_timer.sv
// Gated sixteen-bit timer: clock select, prescaler, gate logic, counter, registers.
// Assumes pins and oscillators are asynchronous to clock; comparator, period-match
// and special event trigger come from logic on clock.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Clock select: 11 RC osc, 10 external, 01 system, 00 instruction clock.
// - Prescale field divides count clock by 1, 2, 4 or 8.
// - With external source, bit 3 picks secondary oscillator, else clock pin.
// - External source: sync bit set bypasses sync (here both flops stay in the path); internal sources ignore it.
// - Run bit 0 enables counting; clear stops the timer.
// - Gate enable ignored when stopped; when running it makes counting gated.
// - Gate polarity set counts while gate high; clear counts while low.
// - Toggle mode: flip-flop toggles on gate rise; clearing mode clears it.
// - Single-pulse mode enables one-shot gate acquisition controlling the gate.
// - Go/done reads 1 while armed awaiting edge, 0 when done or idle (here it reads 0 as soon as the gate opens).
// - Clearing single-pulse mode clears go/done automatically.
// - Gate value bit shows present gate state regardless of gate enable.
// - Gate source: 11 comparator 2, 10 comparator 1, 01 period match, 00 pin.
// - Counter is sixteen bits, readable and writable by software.
// - Special event trigger resets the counter.
// - Unimplemented bits, upper bytes and control bit 1, read as zero.
module gst_timer
  import gst_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [1:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [15:0]      reg_rdata,
  input  wire logic             ext_clock_pin,
  input  wire logic             secondary_oscillator,
  input  wire logic             low_power_rc_osc,
  input  wire logic             gate_input_pin,
  input  wire logic             period_match,
  input  wire logic             comparator1_out,
  input  wire logic             comparator2_out,
  input  wire logic             special_event_trigger,
  output logic                  overflow_pulse,
  output logic      [CNT_W-1:0] count_value
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0]       ctrl_q;
  logic [7:0]       gate_q;
  logic [CNT_W-1:0] count_q;
  logic             ovf_flag_q;
  logic             instr_div_q;
  logic [2:0]       presc_q;
  logic             toggle_q;
  gst_sp_e          sp_q;
  gst_sp_e          sp_d;
  logic             ext_raw_prev_q;
  logic [15:0]      rdata_q;
  logic             ovf_pulse_q;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire logic       timer_run              = ctrl_q[GST_CTRL_RUN];
  wire logic       ext_clock_sync_bypass  = ctrl_q[GST_CTRL_SYNCB];
  wire logic       secondary_osc_select   = ctrl_q[GST_CTRL_OSCSEL];
  wire logic [1:0] input_prescale_select  = ctrl_q[GST_CTRL_PS_LO +: 2];
  wire logic [1:0] count_clock_select     = ctrl_q[GST_CTRL_CS_LO +: 2];
  wire logic [1:0] gate_source_select     = gate_q[GST_GATE_SS_LO +: 2];
  wire logic       gate_single_pulse_mode = gate_q[GST_GATE_SPM];
  wire logic       gate_toggle_mode       = gate_q[GST_GATE_TM];
  wire logic       gate_polarity          = gate_q[GST_GATE_POL];
  wire logic       gate_enable            = gate_q[GST_GATE_EN];

  wire logic wr_ctrl  = reg_wr & (reg_addr == GST_ADDR_CTRL);
  wire logic wr_gate  = reg_wr & (reg_addr == GST_ADDR_GATE);
  wire logic wr_count = reg_wr & (reg_addr == GST_ADDR_COUNT);
  wire logic wr_flag  = reg_wr & (reg_addr == GST_ADDR_FLAG);

  // ----------------------------------------
  // Asynchronous inputs, each through two flip-flops
  // ----------------------------------------
  logic ext_pin_lvl, ext_pin_rise;
  logic secondary_oscillator_lvl, secondary_oscillator_rise;
  logic low_power_rc_osc_rise;
  logic gpin_lvl;

  gst_edge_sync u_sync_ext (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .async_in  (ext_clock_pin),
    .level_out (ext_pin_lvl),
    .rise_out  (ext_pin_rise)
  );
  gst_edge_sync u_sync_secondary_oscillator (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .async_in  (secondary_oscillator),
    .level_out (secondary_oscillator_lvl),
    .rise_out  (secondary_oscillator_rise)
  );
  gst_edge_sync u_sync_low_power_rc_osc (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .async_in  (low_power_rc_osc),
    .level_out (),
    .rise_out  (low_power_rc_osc_rise)
  );
  gst_edge_sync u_sync_gate (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .async_in  (gate_input_pin),
    .level_out (gpin_lvl),
    .rise_out  ()
  );

  // ----------------------------------------
  // Count clock selection
  // ----------------------------------------
  // External source choice
  wire logic ext_lvl  = secondary_osc_select ? secondary_oscillator_lvl : ext_pin_lvl;
  wire logic ext_rise = secondary_osc_select ? secondary_oscillator_rise : ext_pin_rise;
  // A truly unsynchronised path cannot exist in a one-clock design; the bypass
  // keeps both flops, so it sees the same edges as the synchronised path
  wire logic ext_raw_rise = ext_lvl & ~ext_raw_prev_q;
  wire logic ext_tick = ext_clock_sync_bypass ? ext_raw_rise : ext_rise;

  logic src_tick;
  always_comb begin
    case (count_clock_select)
      GST_CS_INSTR: src_tick = instr_div_q;
      GST_CS_SYS:   src_tick = 1'b1;
      GST_CS_EXT:   src_tick = ext_tick;
      GST_CS_LOW_POWER_RC_OSC:  src_tick = low_power_rc_osc_rise;
      default:      src_tick = 1'b0;
    endcase
  end

  function automatic logic presc_done(input logic [1:0] sel, input logic [2:0] cnt);
    case (sel)
      2'h0:    presc_done = 1'b1;
      2'h1:    presc_done = cnt[0];
      2'h2:    presc_done = &cnt[1:0];
      default: presc_done = &cnt;
    endcase
  endfunction

  wire logic presc_tick = src_tick & presc_done(input_prescale_select, presc_q);

  // ----------------------------------------
  // Gate path
  // ----------------------------------------
  logic gate_src;
  always_comb begin
    case (gate_source_select)
      GST_GS_PIN:  gate_src = gpin_lvl;
      GST_GS_MAT:  gate_src = period_match;
      GST_GS_CMP1: gate_src = comparator1_out;
      GST_GS_CMP2: gate_src = comparator2_out;
      default:     gate_src = 1'b0;
    endcase
  end

  logic gate_src_prev_q;
  wire logic gate_pol   = gate_polarity ? gate_src : ~gate_src;
  wire logic gate_pol_p = gate_polarity ? gate_src_prev_q : ~gate_src_prev_q;
  wire logic gate_rise  = gate_pol & ~gate_pol_p;
  wire logic gate_fall  = ~gate_pol & gate_pol_p;
  wire logic tog_out    = gate_toggle_mode ? toggle_q : gate_pol;
  wire logic tog_rise   = gate_toggle_mode ? gate_rise & ~toggle_q : gate_rise;
  wire logic tog_fall   = gate_toggle_mode ? gate_rise & toggle_q : gate_fall;

  // ----------------------------------------
  // Single-pulse acquisition
  // ----------------------------------------
  // Mode bit as it stands after this cycle, so a clearing write drops go/done
  // at once rather than one cycle later
  wire logic spm_next = wr_gate ? reg_wdata[GST_GATE_SPM] : gate_single_pulse_mode;

  // One-shot: armed waits for a rise, then opens until the matching fall
  always_comb begin
    sp_d = sp_q;
    case (sp_q)
      GST_SP_IDLE: if (wr_gate & reg_wdata[GST_GATE_GO] & reg_wdata[GST_GATE_SPM])
                     sp_d = GST_SP_WAIT;
      GST_SP_WAIT: if (tog_rise) sp_d = GST_SP_OPEN;
      GST_SP_OPEN: if (tog_fall) sp_d = GST_SP_IDLE;
      default:     sp_d = GST_SP_IDLE;
    endcase
    if (!spm_next)
      sp_d = GST_SP_IDLE;
  end

  wire logic go_done = (sp_q == GST_SP_WAIT);
  wire logic gate_eff = gate_single_pulse_mode ? (sp_q == GST_SP_OPEN) : tog_out;

  // ----------------------------------------
  // Counter control
  // ----------------------------------------
  // Gate enable only counts while running
  wire logic count_ok = timer_run & (~gate_enable | gate_eff);
  wire logic inc      = count_ok & presc_tick;
  // A load or trigger in the same cycle replaces the step, so no wrap is flagged
  wire logic cnt_step = inc & ~special_event_trigger & ~wr_count;
  wire logic wrap     = cnt_step & (&count_q);

  // ----------------------------------------
  // Sequential state
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q          <= GST_CTRL_RST;
      gate_q          <= GST_GATE_RST;
      sp_q            <= GST_SP_IDLE;
      toggle_q        <= 1'b0;
      gate_src_prev_q <= 1'b0;
      ext_raw_prev_q  <= 1'b0;
      instr_div_q     <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata[7:0] & GST_CTRL_MASK;
      if (wr_gate)
        gate_q <= {reg_wdata[7:4], 2'b00, reg_wdata[1:0]};
      sp_q            <= sp_d;
      gate_src_prev_q <= gate_src;
      ext_raw_prev_q  <= ext_lvl;
      instr_div_q     <= ~instr_div_q;
      if (!gate_toggle_mode)
        toggle_q <= 1'b0;
      else if (gate_rise)
        toggle_q <= ~toggle_q;
    end
  end

  // Prescaler restarts on writes to control or count so a new ratio starts clean
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      presc_q <= 3'h0;
    end else if (clk_en) begin
      if (wr_ctrl | wr_count)
        presc_q <= 3'h0;
      else if (src_tick & count_ok)
        presc_q <= presc_q + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_q     <= GST_COUNT_RST;
      ovf_flag_q  <= 1'b0;
      ovf_pulse_q <= 1'b0;
    end else if (clk_en) begin
      ovf_pulse_q <= wrap;
      if (special_event_trigger)
        count_q <= GST_COUNT_RST;
      else if (wr_count)
        count_q <= reg_wdata[CNT_W-1:0];
      else if (inc)
        count_q <= count_q + CNT_W'(1);
      // Set wins over the software clear
      if (wrap)
        ovf_flag_q <= 1'b1;
      else if (wr_flag & reg_wdata[0])
        ovf_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read port, data one cycle after strobe
  // ----------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      GST_ADDR_CTRL:  rd_mux = {8'h00, ctrl_q};
      GST_ADDR_GATE:  rd_mux = {8'h00, gate_q[7:4], go_done, gate_eff,
                                gate_q[1:0]};
      GST_ADDR_COUNT: rd_mux = 16'(count_q);
      GST_ADDR_FLAG:  rd_mux = {15'h0000, ovf_flag_q};
      default:        rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      rdata_q <= 16'h0000;
    else if (clk_en)
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
  end

  assign reg_rdata      = rdata_q;
  assign overflow_pulse = ovf_pulse_q;
  assign count_value    = count_q;

endmodule
`default_nettype wire

//--- gst_timer_props.sv
// Checker for the gated timer: register port, counter and overflow relations.
// Assumes it is bound to gst_timer and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module gst_timer_props
  import gst_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic             clock,
  input wire logic             sys_rst,
  input wire logic             clk_en,
  input wire logic [1:0]       reg_addr,
  input wire logic [15:0]      reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [15:0]      reg_rdata,
  input wire logic             ext_clock_pin,
  input wire logic             secondary_oscillator,
  input wire logic             low_power_rc_osc,
  input wire logic             gate_input_pin,
  input wire logic             period_match,
  input wire logic             comparator1_out,
  input wire logic             comparator2_out,
  input wire logic             special_event_trigger,
  input wire logic             overflow_pulse,
  input wire logic [CNT_W-1:0] count_value
);
  // ---
  // Run bit shadow
  // ---
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  logic run_q;
  wire  wr_ctl = clk_en && reg_wr && reg_addr == GST_ADDR_CTRL;
  wire  wr_gt  = clk_en && reg_wr && reg_addr == GST_ADDR_GATE;
  wire  rd_ctl = clk_en && reg_rd && reg_addr == GST_ADDR_CTRL;
  wire  rd_gt  = clk_en && reg_rd && reg_addr == GST_ADDR_GATE;
  wire  quiet  = clk_en && !reg_wr && !special_event_trigger;
  always_ff @(posedge clock) begin
    if (sys_rst)
      run_q <= 1'b0;
    else if (wr_ctl)
      run_q <= reg_wdata[GST_CTRL_RUN];
  end
  // ---
  // Properties
  // ---
  a_rdata_idle: assert property ((clk_en && !reg_rd) |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_upper_zero: assert property ((clk_en && reg_rd) |=> reg_rdata[15:8] == 8'h00)
    else $error("upper byte not zero");
  a_ctl_bit1: assert property (rd_ctl |=> !reg_rdata[1])
    else $error("control bit 1 not zero");
  a_ctl_back: assert property (wr_ctl ##1 rd_ctl |=>
    reg_rdata[7:0] == ($past(reg_wdata, 2) & GST_CTRL_MASK))
    else $error("control readback wrong");
  a_go_clear: assert property ((wr_gt && !reg_wdata[GST_GATE_SPM]) ##1 rd_gt |=>
    !reg_rdata[GST_GATE_GO])
    else $error("go/done set without single pulse mode");
  a_cnt_load: assert property ((clk_en && reg_wr && reg_addr == GST_ADDR_COUNT &&
    !special_event_trigger) |=> count_value == $past(reg_wdata))
    else $error("counter write lost");
  a_sevt_clr: assert property ((clk_en && special_event_trigger) |=> count_value == '0)
    else $error("trigger did not clear counter");
  a_cnt_step: assert property (quiet |=>
    count_value == $past(count_value) || count_value == $past(count_value) + 1'b1)
    else $error("counter moved by more than one");
  a_stop_hold: assert property ((quiet && !run_q) |=> $stable(count_value))
    else $error("stopped counter moved");
  a_ovf_wrap: assert property (overflow_pulse |-> count_value == '0 || $past(count_value) == '0)
    else $error("overflow without wrap");
endmodule
bind gst_timer gst_timer_props #(.CNT_W(CNT_W)) i_props (
  .clock, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .ext_clock_pin, .secondary_oscillator, .low_power_rc_osc, .gate_input_pin,
  .period_match, .comparator1_out, .comparator2_out, .special_event_trigger,
  .overflow_pulse, .count_value);
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the gated timer: sources, prescaler, gating, overflow.
// Assumes the checker is compiled before it; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import gst_pkg::*;
;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [1:0]  reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        ext_clock_pin = 1'b0, secondary_oscillator = 1'b0, low_power_rc_osc = 1'b0;
  logic        gate_input_pin = 1'b0, period_match = 1'b0, special_event_trigger = 1'b0;
  logic        comparator1_out = 1'b0, comparator2_out = 1'b0;
  logic [15:0] reg_rdata, count_value, d;
  logic        overflow_pulse;
  logic [3:0]  ph = 4'h0;
  int          n_errors = 0, cmp_count = 0;

  gst_timer #(.CNT_W(16)) i_dut (
    .clock, .sys_rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_clock_pin, .secondary_oscillator, .low_power_rc_osc, .gate_input_pin,
    .period_match, .comparator1_out, .comparator2_out, .special_event_trigger,
    .overflow_pulse, .count_value);

  initial forever #25 clock = ~clock;
  // Free-running sources: pin period 8, oscillator 4, RC 16 cycles
  always @(posedge clock) begin
    ph <= ph + 4'h1;
    ext_clock_pin <= ph[2];
    secondary_oscillator <= ph[1];
    low_power_rc_osc <= ph[3];
  end
  // ---
  // Shared tasks
  // ---
  task automatic chk(input string nm, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Write then read with no idle cycle between the strobes
  task automatic wrrd(input logic [1:0] a, input logic [15:0] v, output logic [15:0] q);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // Settle covers synchroniser latency before the window opens
  task automatic span(input int n, ex, tl);
    logic [15:0] c0;
    repeat (6) @(posedge clock);
    #1 c0 = count_value;
    repeat (n) @(posedge clock);
    #1 c0 = count_value - c0;
    chk("count_delta", {15'h0, int'(c0) >= ex - tl && int'(c0) <= ex + tl}, 16'h1);
    @(posedge clock);
  endtask
  task automatic meas(input logic [15:0] ct, gt, input int n, ex, tl);
    wr(GST_ADDR_GATE, gt);
    wr(GST_ADDR_CTRL, ct);
    span(n, ex, tl);
  endtask
  task automatic src(input int s, l);
    @(posedge clock);
    gate_input_pin <= s == 0 && l != 0;
    period_match <= s == 1 && l != 0;
    comparator1_out <= s == 2 && l != 0;
    comparator2_out <= s == 3 && l != 0;
  endtask
  // ---
  // Scenarios
  // ---
  task automatic t_regs();
    rd(GST_ADDR_CTRL, d);
    chk("ctrl_rst", d, 16'h0000);
    rd(GST_ADDR_GATE, d);
    chk("gate_rst", d & 16'hFFFB, 16'h0000);
    rd(GST_ADDR_COUNT, d);
    chk("count_rst", d, 16'h0000);
    wrrd(GST_ADDR_CTRL, 16'hFFFE, d);
    chk("ctrl_bits", d, 16'h00FC);
    wrrd(GST_ADDR_GATE, 16'hFFE3, d);
    chk("gate_bits", d & 16'hFFFB, 16'h00E3);
  endtask
  task automatic t_src();
    logic [15:0] ct [4] = '{16'h0081, 16'h0085, 16'h0089, 16'h00C1};
    int ex [4] = '{8, 8, 16, 4};
    for (int c = 0; c < 2; c++)
      for (int p = 0; p < 4; p++)
        meas({8'h00, c[1:0], p[1:0], 4'h1}, 16'h0000, 32, 32 >> (p + (c == 0)), 0);
    for (int k = 0; k < 4; k++)
      meas(ct[k], 16'h0000, 64, ex[k], 1);
    meas(16'h0040, 16'h0000, 32, 0, 0);
  endtask
  task automatic t_gate();
    for (int s = 0; s < 4; s++)
      for (int l = 0; l < 2; l++) begin
        src(s, l);
        meas(16'h0041, {8'h00, 6'h30, s[1:0]}, 32, 32 * l, 0);
        rd(GST_ADDR_GATE, d);
        chk("gate_val", {15'h0, d[GST_GATE_VAL]}, l[15:0]);
      end
    src(0, 0);
    meas(16'h0041, 16'h0080, 32, 32, 0);
    meas(16'h0041, 16'h0040, 32, 32, 0);
    src(0, 1);
    meas(16'h0040, 16'h00C0, 32, 0, 0);
    src(0, 0);
    meas(16'h0041, 16'h00E0, 32, 0, 0);
    for (int k = 0; k < 2; k++) begin
      gate_input_pin <= 1'b1;
      repeat (4) @(posedge clock);
      gate_input_pin <= 1'b0;
      span(32, 32 * (1 - k), 0);
    end
  endtask
  task automatic t_spm();
    wr(GST_ADDR_GATE, 16'h00D8);
    rd(GST_ADDR_GATE, d);
    chk("armed", {15'h0, d[GST_GATE_GO]}, 16'h1);
    wr(GST_ADDR_CTRL, 16'h0041);
    span(32, 0, 0);
    gate_input_pin <= 1'b1;
    span(32, 32, 0);
    gate_input_pin <= 1'b0;
    rd(GST_ADDR_GATE, d);
    chk("done", {15'h0, d[GST_GATE_GO]}, 16'h0);
    @(posedge clock);
    gate_input_pin <= 1'b1;
    span(32, 0, 0);
    gate_input_pin <= 1'b0;
    wr(GST_ADDR_GATE, 16'h00D8);
    wrrd(GST_ADDR_GATE, 16'h00C0, d);
    chk("go_cleared", {15'h0, d[GST_GATE_GO]}, 16'h0);
  endtask
  task automatic t_evt();
    int i = 0;
    meas(16'h0001, 16'h0000, 8, 4, 0);
    clk_en <= 1'b0;
    @(posedge clock);
    #1 d = count_value;
    repeat (8) @(posedge clock);
    #1 chk("freeze", count_value, d);
    @(posedge clock);
    clk_en <= 1'b1;
    special_event_trigger <= 1'b1;
    @(posedge clock);
    special_event_trigger <= 1'b0;
    #1 chk("event_clear", count_value, 16'h0000);
    wr(GST_ADDR_COUNT, 16'hFFF0);
    while (overflow_pulse !== 1'b1 && i < 60) begin
      @(posedge clock);
      #1 i++;
    end
    chk("ovf_pulse", {15'h0, overflow_pulse}, 16'h1);
    rd(GST_ADDR_FLAG, d);
    chk("flag_set", d, 16'h0001);
    wr(GST_ADDR_CTRL, 16'h0000);
    wr(GST_ADDR_FLAG, 16'h0001);
    rd(GST_ADDR_FLAG, d);
    chk("flag_clr", d, 16'h0000);
    wr(GST_ADDR_COUNT, 16'h1234);
    rd(GST_ADDR_COUNT, d);
    chk("count_rw", d, 16'h1234);
  endtask
  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Budget is several times the expected run length
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_src();
    t_gate();
    t_spm();
    t_evt();
    summarize();
  end
endmodule
`default_nettype wire
